/* File: rtl/dac_serial_load.sv */
// Serial load control for a dual voltage-output DAC.
// Assumes all pins are asynchronous to clk; serial clock well below clk/4.
// Function
// R1: Hold a 24-bit shift register capturing serial data on falling edges.
// R2: Frame sync low opens a frame; next 24 falling edges carry data.
// R3: Host keeps the serial clock at or below 50 MHz; the design needs it well below clk/4 (12.5 MHz at 50 MHz clk).
// R4: Serial output changes on rising edges, valid at the next falling edge.
// R5: Strobe low copies input registers into selected DAC registers together.
// R6: Asynchronous and synchronous strobe modes; strobe tied low allowed.
// R7: Device reset acts on its falling edge, independent of serial clock.
// R8: Strobe pulses are ignored while device reset is low.
// R9: Reset loads input and DAC registers with zero or midscale.
// R10: Held reset at power-up delays initialisation until release.
// R11: Power-up sets zero scale on select low, midscale on select high.
// R12: Gain select low gives span 0..Vref, high gives 0..2 Vref.
// R13: Act on a frame only after all 24 bits; discard shorter frames.
`timescale 1ns/1ps
module dac_serial_load (
  // Clock and power-on reset
  input wire logic clk,
  input wire logic arst_n,
  // Serial link pins
  input wire logic serial_clk,
  input wire logic frame_sync_n,
  input wire logic serial_in,
  output logic serial_out,
  // Control pins
  input wire logic load_update_strobe_n,
  input wire logic sync_load_mode,
  input wire logic device_reset_n,
  input wire logic reset_scale_select,
  input wire logic gain_select,
  // Converter codes and span
  output logic [15:0] channel_a_output,
  output logic [15:0] channel_b_output,
  output logic span_double
);
  logic [4:0] pins_sync;
  logic sclk_s, sync_n_s, din_s, load_update_strobe_n_n_s, rst_n_s;
  logic sclk_d_reg, sync_d_reg, rst_d_reg, load_update_strobe_n_d_reg;
  logic init_done_reg;
  logic [23:0] shift_reg;
  logic [4:0] cnt_reg;
  logic [15:0] in_a_reg, in_b_reg;
  logic new_a_reg, new_b_reg, pend_reg;
  logic frame_done_reg;
  logic [2:0] ctl_sync;
  logic mode_s, rss_s, gain_s;
  dac_ctrl_pkg::frame_state_t state_reg, state_next;

  // Samples link clock as data; no second clock domain
  pin_sync #(.WIDTH(5), .INIT(5'h1E)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_in({serial_clk, frame_sync_n, serial_in,
               load_update_strobe_n, device_reset_n}),
    .sync_out(pins_sync)
  );
  assign sclk_s = pins_sync[4];
  assign sync_n_s = pins_sync[3];
  assign din_s = pins_sync[2];
  assign load_update_strobe_n_n_s = pins_sync[1];
  assign rst_n_s = pins_sync[0];

  // Straps are pins too; rewiring them live must not go metastable
  pin_sync #(.WIDTH(3), .INIT(3'h0)) u_sync_ctl (
    .clk(clk),
    .arst_n(arst_n),
    .async_in({sync_load_mode, reset_scale_select, gain_select}),
    .sync_out(ctl_sync)
  );
  assign mode_s = ctl_sync[2];
  assign rss_s = ctl_sync[1];
  assign gain_s = ctl_sync[0];

  wire sclk_fall = sclk_d_reg && !sclk_s;
  wire sclk_rise = !sclk_d_reg && sclk_s;
  wire sync_fall = sync_d_reg && !sync_n_s;
  wire sync_rise = !sync_d_reg && sync_n_s;
  wire rst_fall = rst_d_reg && !rst_n_s;
  wire load_update_strobe_n_fall = load_update_strobe_n_d_reg && !load_update_strobe_n_n_s;
  wire in_frame = !sync_n_s;
  wire take_bit = in_frame && sclk_fall &&
                  (cnt_reg != dac_ctrl_pkg::FRAME_COUNT);
  wire frame_ok = sync_rise && (state_reg == dac_ctrl_pkg::ST_FULL);
  wire [15:0] rx_code = shift_reg[dac_ctrl_pkg::CODE_LSB +: 16];
  wire sel_a = shift_reg[dac_ctrl_pkg::ADDR_A_BIT];
  wire sel_b = shift_reg[dac_ctrl_pkg::ADDR_B_BIT];
  wire [15:0] reset_code = rss_s ? dac_ctrl_pkg::MID_SCALE
                                 : dac_ctrl_pkg::ZERO_SCALE;
  // Sync mode waits one cycle after frame end so the pending flag is set
  wire load_update_strobe_n_event = rst_n_s && init_done_reg &&
                    (mode_s ? (frame_done_reg && !load_update_strobe_n_n_s)
                            : (load_update_strobe_n_fall || !load_update_strobe_n_n_s));
  wire do_reset = rst_fall || (!init_done_reg && rst_n_s);

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      dac_ctrl_pkg::ST_IDLE:
        if (sync_fall)
          state_next = dac_ctrl_pkg::ST_SHIFT;
      dac_ctrl_pkg::ST_SHIFT:
        if (sync_n_s)
          state_next = dac_ctrl_pkg::ST_IDLE;
        else if (take_bit && cnt_reg == dac_ctrl_pkg::FRAME_COUNT - 1)
          state_next = dac_ctrl_pkg::ST_FULL;
      dac_ctrl_pkg::ST_FULL:
        if (sync_n_s)
          state_next = dac_ctrl_pkg::ST_IDLE;
      default:
        state_next = dac_ctrl_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      // Match synchroniser reset values so no false edge follows reset
      sclk_d_reg <= 1'b1;
      sync_d_reg <= 1'b1;
      rst_d_reg <= 1'b0;
      load_update_strobe_n_d_reg <= 1'b1;
      state_reg <= dac_ctrl_pkg::ST_IDLE;
      frame_done_reg <= 1'b0;
    end
    else
    begin
      sclk_d_reg <= sclk_s;
      sync_d_reg <= sync_n_s;
      rst_d_reg <= rst_n_s;
      load_update_strobe_n_d_reg <= load_update_strobe_n_n_s;
      state_reg <= state_next;
      frame_done_reg <= frame_ok; // R6
    end
  end

  // Frame bit counter and shift register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_reg <= dac_ctrl_pkg::CNT_ZERO;
      shift_reg <= dac_ctrl_pkg::FRAME_ZERO;
    end
    else if (sync_fall)
      cnt_reg <= dac_ctrl_pkg::CNT_ZERO; // R2
    else if (take_bit)
    begin
      cnt_reg <= cnt_reg + dac_ctrl_pkg::CNT_ONE; // R2
      shift_reg <= {shift_reg[22:0], din_s}; // R1
    end
  end

  // Output changes on rising edge so host samples it on the falling edge
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      serial_out <= 1'b0;
    else if (in_frame && sclk_rise)
      serial_out <= shift_reg[23]; // R4
  end

  // Initialisation waits for device reset high after power-on
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      init_done_reg <= 1'b0;
    else if (rst_n_s)
      init_done_reg <= 1'b1; // R10
  end

  // Input and DAC registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      in_a_reg <= dac_ctrl_pkg::ZERO_SCALE;
      in_b_reg <= dac_ctrl_pkg::ZERO_SCALE;
      channel_a_output <= dac_ctrl_pkg::ZERO_SCALE;
      channel_b_output <= dac_ctrl_pkg::ZERO_SCALE;
      new_a_reg <= 1'b0;
      new_b_reg <= 1'b0;
    end
    else if (do_reset)
    begin
      in_a_reg <= reset_code; // R9 R11 R7
      in_b_reg <= reset_code; // R9 R11
      channel_a_output <= reset_code; // R9 R11
      channel_b_output <= reset_code; // R9 R11
      new_a_reg <= 1'b0;
      new_b_reg <= 1'b0;
    end
    else
    begin
      if (frame_ok && sel_a)
        in_a_reg <= rx_code; // R13
      if (frame_ok && sel_b)
        in_b_reg <= rx_code; // R13
      // A new frame landing with the update keeps its pending flag
      if (load_update_strobe_n_event && new_a_reg)
        channel_a_output <= in_a_reg; // R5 R6 R8
      if (load_update_strobe_n_event && new_b_reg)
        channel_b_output <= in_b_reg; // R5 R6 R8
      new_a_reg <= (frame_ok && sel_a) || (new_a_reg && !load_update_strobe_n_event);
      new_b_reg <= (frame_ok && sel_b) || (new_b_reg && !load_update_strobe_n_event);
    end
  end

  // Span select passed to analog output stage
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      span_double <= 1'b0;
    else
      span_double <= gain_s; // R12
  end

  assign pend_reg = new_a_reg || new_b_reg;

  AST_FRAME_COUNT: assert property (@(posedge clk) disable iff (!arst_n)
    take_bit |=> cnt_reg == $past(cnt_reg) + 5'h01) // R2
    else $error("bit count did not advance");
  AST_SHIFT_IN: assert property (@(posedge clk) disable iff (!arst_n)
    take_bit |=> shift_reg[0] == $past(din_s)) // R1
    else $error("serial bit not captured");
  AST_SHORT_DROP: assert property (@(posedge clk) disable iff (!arst_n)
    (sync_rise && state_reg != dac_ctrl_pkg::ST_FULL && !do_reset)
    |=> in_a_reg == $past(in_a_reg)) // R13
    else $error("short frame changed input register");
  AST_RESET_LOAD: assert property (@(posedge clk) disable iff (!arst_n)
    rst_fall |=> channel_a_output == $past(reset_code)
             && in_b_reg == $past(reset_code)) // R9
    else $error("reset did not load scale");
  AST_LOAD_UPDATE_STROBE_N_IGNORED: assert property (@(posedge clk) disable iff (!arst_n)
    (!rst_n_s && !rst_fall && init_done_reg)
    |=> $stable(channel_b_output) && $stable(channel_a_output)) // R8
    else $error("update during reset");
  AST_UPDATE: assert property (@(posedge clk) disable iff (!arst_n)
    (load_update_strobe_n_event && new_a_reg && !do_reset)
    |=> channel_a_output == $past(in_a_reg)) // R5
    else $error("DAC register not updated");
  AST_SDO_EDGE: assert property (@(posedge clk) disable iff (!arst_n)
    !(in_frame && sclk_rise) |=> $stable(serial_out)) // R4
    else $error("serial output moved off rising edge");
  AST_INIT_WAIT: assert property (@(posedge clk) disable iff (!arst_n)
    (!init_done_reg && !rst_n_s)
    |=> $stable(channel_a_output) && $stable(channel_b_output)) // R10
    else $error("update before initialisation");
  AST_SPAN: assert property (@(posedge clk) disable iff (!arst_n)
    ##1 span_double == $past(gain_select, 3)) // R12
    else $error("span not following gain select");
  COV_FRAME: cover property (@(posedge clk) disable iff (!arst_n) frame_ok);
  COV_LOAD_UPDATE_STROBE_N: cover property (@(posedge clk) disable iff (!arst_n)
    load_update_strobe_n_event && pend_reg);
  COV_RESET: cover property (@(posedge clk) disable iff (!arst_n) rst_fall);
  COV_SHORT: cover property (@(posedge clk) disable iff (!arst_n)
    sync_rise && state_reg == dac_ctrl_pkg::ST_SHIFT);
endmodule

/* File: rtl/dac_ctrl_pkg.sv */
// Constants for the dual DAC serial load front end.
// Assumes a single 50 MHz system clock samples all pins.
package dac_ctrl_pkg;
  localparam int FRAME_BITS = 24;
  localparam int CODE_BITS = 16;
  localparam int CNT_BITS = 5;
  localparam logic [4:0] FRAME_COUNT = 5'h18;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam logic [15:0] ZERO_SCALE = 16'h0000;
  localparam logic [15:0] MID_SCALE = 16'h8000;
  localparam logic [23:0] FRAME_ZERO = 24'h000000;
  // Frame layout: address nibble selects channels, low 16 bits carry code
  localparam int ADDR_A_BIT = 16;
  localparam int ADDR_B_BIT = 17;
  localparam int CODE_LSB = 0;
  localparam int CLK_MHZ = 50;
  localparam int SCLK_MAX_MHZ = 50;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_FULL = 2'b10
  } frame_state_t;
endpackage

/* File: rtl/pin_sync.sv */
// Two-flop synchroniser bank for pins entering the clk domain.
// Assumes inputs are asynchronous; output only from second flop.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_reg <= INIT;
      sync_out <= INIT;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

/* File: sim/host_spi_model.sv */
// Host side model: frames, serial clock and data for the link.
// Assumes the device samples these pins with its own clock.
`timescale 1ns/1ps
module host_spi_model (
  // Link pins
  output logic serial_clk,
  output logic frame_sync_n,
  output logic serial_in,
  input wire logic serial_out
);
  logic [23:0] seen;
  initial
  begin
    serial_clk = 1'b1;
    frame_sync_n = 1'b1;
    serial_in = 1'b0;
    seen = 24'h000000;
  end
  // Clock idles high between frames; 160 ns period
  task automatic send(input logic [23:0] word, input int nbits);
    int i;
    #7 frame_sync_n = 1'b0;
    for (i = 0; i < nbits; i++)
    begin
      serial_in = word[23 - i];
      #80 serial_clk = 1'b0;
      // Sampled late: device output crosses a synchroniser
      #80 seen = {seen[22:0], serial_out};
      serial_clk = 1'b1;
    end
    #20 frame_sync_n = 1'b1;
    serial_in = ~serial_in;
    #200;
  endtask
endmodule

/* File: sim/dac_serial_load_tb_top.sv */
// Bench for the dual DAC serial load front end.
// Assumes the host model drives the link pins.
`timescale 1ns/1ps
module dac_serial_load_tb_top;
  logic clk;
  logic arst_n;
  logic serial_clk;
  logic frame_sync_n;
  logic serial_in;
  logic serial_out;
  logic load_update_strobe_n;
  logic sync_load_mode;
  logic device_reset_n;
  logic reset_scale_select;
  logic gain_select;
  logic [15:0] channel_a_output;
  logic [15:0] channel_b_output;
  logic span_double;
  int n_errors = 0;
  int tests_run = 0;
  dac_serial_load uut (
    .clk, .arst_n, .serial_clk, .frame_sync_n, .serial_in, .serial_out,
    .load_update_strobe_n, .sync_load_mode, .device_reset_n,
    .reset_scale_select, .gain_select, .channel_a_output,
    .channel_b_output, .span_double
  );
  host_spi_model host (.serial_clk, .frame_sync_n, .serial_in, .serial_out);
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic strobe_pulse();
    load_update_strobe_n = 1'b0;
    idle(6);
    load_update_strobe_n = 1'b1;
    idle(8);
  endtask
  task automatic frame(input logic [23:0] w, input int n);
    host.send(w, n);
    idle(8);
  endtask
  task automatic t_power_up();
    idle(12);
    check(channel_a_output, 16'h0000);
    device_reset_n = 1'b1;
    idle(8);
    check(channel_a_output, 16'h8000);
    check(channel_b_output, 16'h8000);
    $display("power up done");
  endtask
  task automatic t_async_load();
    frame(24'h01ABCD, 24);
    check(channel_a_output, 16'h8000);
    strobe_pulse();
    check(channel_a_output, 16'hABCD);
    check(channel_b_output, 16'h8000);
    $display("async load done");
  endtask
  task automatic t_held_low();
    load_update_strobe_n = 1'b0;
    frame(24'h031234, 24);
    check(host.seen[15:0], 16'hABCD);
    check(channel_a_output, 16'h1234);
    check(channel_b_output, 16'h1234);
    frame(24'h025555, 24);
    check(host.seen[15:0], 16'h1234);
    check(channel_b_output, 16'h5555);
    check(channel_a_output, 16'h1234);
    load_update_strobe_n = 1'b1;
    $display("held low done");
  endtask
  task automatic t_short_frame();
    frame(24'h01FFFF, 20);
    strobe_pulse();
    check(channel_a_output, 16'h1234);
    $display("short frame done");
  endtask
  task automatic t_sync_mode();
    sync_load_mode = 1'b1;
    load_update_strobe_n = 1'b0;
    frame(24'h010F0F, 24);
    check(channel_a_output, 16'h0F0F);
    load_update_strobe_n = 1'b1;
    frame(24'h02F0F0, 24);
    check(channel_b_output, 16'h5555);
    sync_load_mode = 1'b0;
    $display("sync mode done");
  endtask
  task automatic t_device_reset();
    reset_scale_select = 1'b0;
    device_reset_n = 1'b0;
    idle(8);
    check(channel_a_output, 16'h0000);
    check(channel_b_output, 16'h0000);
    frame(24'h03AAAA, 24);
    strobe_pulse();
    check(channel_a_output, 16'h0000);
    device_reset_n = 1'b1;
    idle(8);
    $display("device reset done");
  endtask
  task automatic t_gain();
    gain_select = 1'b1;
    idle(6);
    check(16'(span_double), 16'h0001);
    gain_select = 1'b0;
    idle(6);
    check(16'(span_double), 16'h0000);
    $display("gain done");
  endtask
  initial
  begin
    arst_n = 1'b0;
    load_update_strobe_n = 1'b1;
    sync_load_mode = 1'b0;
    device_reset_n = 1'b0;
    reset_scale_select = 1'b1;
    gain_select = 1'b0;
    idle(8);
    arst_n = 1'b1;
    t_power_up();
    t_async_load();
    t_held_low();
    t_short_frame();
    t_sync_mode();
    t_device_reset();
    t_gain();
    complete_run();
  end
  // About 31 us of traffic; allow a wide margin
  initial
  begin
    #300000;
    n_errors++;
    complete_run();
  end
endmodule
